// *** src/rstc_ctrl.sv ***
// radio state timing and control block with apb register slave
`timescale 1ns/100ps
`default_nettype none
module rstc_ctrl
  import rstc_pkg::*;
#(
  parameter int IDLE_ACT_CAL = CYC_IDLE_ACT_CAL,
  parameter int TX_IDLE_CAL  = CYC_TX_IDLE_CAL,
  parameter int RX_IDLE_CAL  = CYC_RX_IDLE_CAL,
  parameter int MAN_CAL      = CYC_MAN_CAL
) (
  // clock and reset
  input  wire logic         pclk,
  input  wire logic         presetn,
  // apb slave
  input  wire logic         psel,
  input  wire logic         penable,
  input  wire logic         pwrite,
  input  wire logic [7:0]   paddr,
  input  wire logic [31:0]  pwdata,
  output logic              pready,
  output logic [31:0]       prdata,
  output logic              pslverr,
  // radio side
  input  wire logic         quarter_sym_tick,
  input  wire rstc_rx_ind_t rx_ind,
  output logic              rx_active_ff,
  output logic              tx_active_ff,
  output logic              synth_on_ff,
  output logic              cal_busy_ff,
  output logic [7:0]        output_power_setting_ff
);

  typedef enum logic [3:0] {
    S_IDLE, S_TO_RX, S_TO_TX, S_TO_FSTX, S_RX, S_TX, S_FSTX,
    S_RX_TO_IDLE, S_TX_TO_IDLE, S_TX_CAL, S_MANCAL, S_RX_CAL
  } rstc_state_t;

  //////////////////////////////////////////////////////////////////////////
  // registers
  rstc_state_t state_ff;
  logic [31:0] cnt_ff;
  logic        qsym_wait_ff;
  logic [15:0] rxtimer_ff;
  logic        cs_seen_ff;
  logic [1:0]  autocnt_ff;
  logic [7:0]  ctrl_ff;
  logic [23:0] carrier_base_word_ff;
  logic [7:0]  spacing_mantissa_ff;
  logic [1:0]  spacing_exponent_ff;
  logic [7:0]  slot_index_ff;
  logic [4:0]  intermediate_tune_word_ff;
  logic [15:0] rx_timeout_ff;
  logic [4:0]  strobe_ff;
  logic [31:0] carrier_word_ff;
  logic [31:0] spacing_word_ff;

  logic        wr_en;
  logic        rd_en;
  logic        qual;
  logic        csterm;
  rstc_cal_mode_t cal_mode;
  rstc_off_t   rxoff;
  rstc_off_t   txoff;

  assign wr_en    = psel & penable & pwrite;
  assign rd_en    = psel & penable & ~pwrite;
  assign cal_mode = rstc_cal_mode_t'(ctrl_ff[CTL_CAL_LSB +: 2]);
  assign qual     = ctrl_ff[CTL_QUAL];
  assign csterm   = ctrl_ff[CTL_CSTERM];
  assign rxoff    = rstc_off_t'(ctrl_ff[CTL_RXOFF_LSB +: 2]);
  assign txoff    = rstc_off_t'(ctrl_ff[CTL_TXOFF_LSB +: 2]);

  // true when an automatic return to idle must calibrate
  function automatic logic auto_cal(input rstc_cal_mode_t m,
                                    input logic [1:0] c);
    auto_cal = (m == RSTC_CAL_TO_IDLE) ||
               ((m == RSTC_CAL_FOURTH) && (c == 2'(CYC_AUTO_PERIOD - 1)));
  endfunction : auto_cal

  //////////////////////////////////////////////////////////////////////////
  // apb write side; strobes live one cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_ff                   <= RST_CTRL;
      carrier_base_word_ff      <= RST_BASE;
      spacing_mantissa_ff       <= RST_MANT;
      spacing_exponent_ff       <= RST_EXP;
      slot_index_ff             <= RST_SLOT;
      intermediate_tune_word_ff <= RST_IFTUNE;
      output_power_setting_ff   <= RST_POWER;
      rx_timeout_ff             <= RST_RXTIME;
      strobe_ff                 <= 5'h00;
    end else begin
      strobe_ff <= 5'h00;
      if (wr_en) begin
        case (paddr)
          OFS_CTRL:    ctrl_ff <= pwdata[7:0];
          OFS_STROBE:  strobe_ff <= pwdata[4:0];
          OFS_BASE:    carrier_base_word_ff <= pwdata[23:0];
          OFS_SPACING: begin
            spacing_mantissa_ff <= pwdata[7:0];
            spacing_exponent_ff <= pwdata[9:8];
          end
          OFS_SLOT:    slot_index_ff <= pwdata[7:0];
          OFS_IFTUNE:  intermediate_tune_word_ff <= pwdata[4:0];
          OFS_POWER:   output_power_setting_ff <= pwdata[7:0];
          OFS_RXTIME:  rx_timeout_ff <= pwdata[15:0];
          default: ;
        endcase
      end
    end
  end

  // apb read side; zero wait states, unmapped reads zero, never an error
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata  <= 32'h00000000;
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready  <= psel & ~penable;
      pslverr <= 1'b0;
      if (psel & ~penable & ~pwrite) begin
        case (paddr)
          OFS_CTRL:    prdata <= {24'h000000, ctrl_ff};
          OFS_BASE:    prdata <= {8'h00, carrier_base_word_ff};
          OFS_SPACING: prdata <= {22'h000000, spacing_exponent_ff,
                                  spacing_mantissa_ff};
          OFS_SLOT:    prdata <= {24'h000000, slot_index_ff};
          OFS_IFTUNE:  prdata <= {27'h0000000, intermediate_tune_word_ff};
          OFS_POWER:   prdata <= {24'h000000, output_power_setting_ff};
          OFS_RXTIME:  prdata <= {16'h0000, rx_timeout_ff};
          OFS_STATUS:  prdata <= {26'h0000000, autocnt_ff, state_ff};
          OFS_CARRIER: prdata <= carrier_word_ff;
          OFS_SPCWORD: prdata <= spacing_word_ff;
          OFS_IFWORD:  prdata <= {27'h0000000, intermediate_tune_word_ff};
          default:     prdata <= 32'h00000000;
        endcase
      end else if (rd_en) begin
        prdata <= prdata;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // frequency word arithmetic, units of fref/2^18 for spacing and
  // fref/2^16 for carrier; software keeps these still outside idle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      spacing_word_ff <= 32'h00000000;
      carrier_word_ff <= 32'h00000000;
    end else begin
      spacing_word_ff <= 32'(9'h100 + 9'(spacing_mantissa_ff))
                         << spacing_exponent_ff;
      // slot*(256+m)*2^e/4 in fref/2^16 units, kept with two fraction bits
      carrier_word_ff <= 32'({carrier_base_word_ff, 2'b00}) +
                         32'(slot_index_ff) * spacing_word_ff;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // radio state machine with transition counters
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_ff     <= S_IDLE;
      cnt_ff       <= 32'h00000000;
      qsym_wait_ff <= 1'b0;
      rxtimer_ff   <= 16'h0000;
      cs_seen_ff   <= 1'b0;
      autocnt_ff   <= 2'h0;
    end else begin
      if (cnt_ff != 32'h00000000) begin
        cnt_ff <= cnt_ff - 32'h00000001;
      end
      if (strobe_ff[STB_IDLE] && state_ff != S_IDLE) begin
        state_ff     <= S_IDLE;
        cnt_ff       <= 32'h00000000;
        qsym_wait_ff <= 1'b0;
      end else begin
        case (state_ff)
          S_IDLE: begin
            if (strobe_ff[STB_CAL]) begin
              state_ff <= S_MANCAL;
              cnt_ff   <= 32'(MAN_CAL - 1);
            end else if (strobe_ff[STB_RX]) begin
              state_ff <= S_TO_RX;
              cnt_ff   <= (cal_mode == RSTC_CAL_TO_ACTIVE) ?
                          32'(IDLE_ACT_CAL - 1) :
                          32'(CYC_IDLE_RX - 1);
            end else if (strobe_ff[STB_TX] || strobe_ff[STB_FSTX]) begin
              state_ff <= strobe_ff[STB_TX] ? S_TO_TX : S_TO_FSTX;
              cnt_ff   <= (cal_mode == RSTC_CAL_TO_ACTIVE) ?
                          32'(IDLE_ACT_CAL - 1) :
                          32'(CYC_IDLE_TX - 1);
            end
          end
          S_TO_RX: if (cnt_ff == 32'h00000000 && !qsym_wait_ff) begin
            state_ff   <= S_RX;
            rxtimer_ff <= rx_timeout_ff;
            cs_seen_ff <= 1'b0;
          end else if (cnt_ff == 32'h00000000 && quarter_sym_tick) begin
            qsym_wait_ff <= 1'b0;
          end
          S_TO_TX, S_TO_FSTX: if (cnt_ff == 32'h00000000) begin
            state_ff <= (state_ff == S_TO_TX) ? S_TX : S_FSTX;
          end
          S_FSTX: if (strobe_ff[STB_TX]) begin
            state_ff <= S_TX;
          end else if (strobe_ff[STB_RX]) begin
            state_ff <= S_TO_RX;
            cnt_ff   <= 32'(CYC_TURN - 1);
          end
          S_RX: begin
            if (rxtimer_ff != 16'h0000) begin
              rxtimer_ff <= rxtimer_ff - 16'h0001;
            end
            if (rx_ind.cs_valid) begin
              cs_seen_ff <= 1'b1;
            end
            if (strobe_ff[STB_TX] || strobe_ff[STB_FSTX]) begin
              state_ff <= strobe_ff[STB_TX] ? S_TO_TX : S_TO_FSTX;
              cnt_ff   <= 32'(CYC_TURN - 1);
            end else if (csterm && rx_ind.cs_valid && !cs_seen_ff &&
                         !rx_ind.cs_carrier) begin
              // a termination is an automatic return, so it may calibrate
              state_ff   <= auto_cal(cal_mode, autocnt_ff) ?
                            S_RX_CAL : S_RX_TO_IDLE;
              cnt_ff     <= auto_cal(cal_mode, autocnt_ff) ?
                            32'(RX_IDLE_CAL - 1) :
                            32'(CYC_RX_IDLE - 1);
              autocnt_ff <= autocnt_ff + 2'h1;
            end else if (rx_timeout_ff != 16'h0000 &&
                         rxtimer_ff == 16'h0001 && !rx_ind.sync_found &&
                         !(qual && rx_ind.pqt_above)) begin
              state_ff   <= auto_cal(cal_mode, autocnt_ff) ?
                            S_RX_CAL : S_RX_TO_IDLE;
              cnt_ff     <= auto_cal(cal_mode, autocnt_ff) ?
                            32'(RX_IDLE_CAL - 1) :
                            32'(CYC_RX_IDLE - 1);
              autocnt_ff <= autocnt_ff + 2'h1;
            end else if (rx_ind.pkt_done) begin
              case (rxoff)
                RSTC_OFF_IDLE: begin
                  state_ff   <= auto_cal(cal_mode, autocnt_ff) ?
                                S_RX_CAL : S_RX_TO_IDLE;
                  cnt_ff     <= auto_cal(cal_mode, autocnt_ff) ?
                                32'(RX_IDLE_CAL - 1) :
                                32'(CYC_RX_IDLE - 1);
                  autocnt_ff <= autocnt_ff + 2'h1;
                end
                RSTC_OFF_FSTX: state_ff <= S_FSTX;
                RSTC_OFF_TX: begin
                  state_ff <= S_TO_TX;
                  cnt_ff   <= 32'(CYC_TURN - 1);
                end
                default: rxtimer_ff <= rx_timeout_ff;
              endcase
            end
          end
          S_TX: if (strobe_ff[STB_RX]) begin
            state_ff     <= S_TO_RX;
            cnt_ff       <= 32'(CYC_TURN - 1);
            qsym_wait_ff <= 1'b1;
          end else if (rx_ind.pkt_done) begin
            case (txoff)
              RSTC_OFF_IDLE: begin
                state_ff     <= S_TX_TO_IDLE;
                qsym_wait_ff <= auto_cal(cal_mode, autocnt_ff);
                autocnt_ff   <= autocnt_ff + 2'h1;
              end
              RSTC_OFF_FSTX: state_ff <= S_FSTX;
              RSTC_OFF_RX: begin
                state_ff     <= S_TO_RX;
                cnt_ff       <= 32'(CYC_TURN - 1);
                qsym_wait_ff <= 1'b1;
              end
              default: ;
            endcase
          end
          S_TX_TO_IDLE: if (quarter_sym_tick) begin
            if (qsym_wait_ff) begin
              state_ff <= S_TX_CAL;
              cnt_ff   <= 32'(TX_IDLE_CAL - 1);
            end else begin
              state_ff <= S_IDLE;
            end
            qsym_wait_ff <= 1'b0;
          end
          S_RX_TO_IDLE, S_RX_CAL, S_TX_CAL, S_MANCAL: begin
            if (cnt_ff == 32'h00000000) begin
              state_ff <= S_IDLE;
            end
          end
          default: state_ff <= S_IDLE;
        endcase
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // registered radio outputs; calibration results live in the analog
  // block and are untouched by this path, whose flops presetn clears to zero
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rx_active_ff <= 1'b0;
      tx_active_ff <= 1'b0;
      synth_on_ff  <= 1'b0;
      cal_busy_ff  <= 1'b0;
    end else begin
      rx_active_ff <= (state_ff == S_RX);
      tx_active_ff <= (state_ff == S_TX);
      synth_on_ff  <= (state_ff != S_IDLE) && (state_ff != S_MANCAL);
      cal_busy_ff  <= (state_ff == S_MANCAL) || (state_ff == S_TX_CAL) ||
                      (state_ff == S_RX_CAL);
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // checks
  a_manual_cal_len: assert property (@(posedge pclk) disable iff (!presetn)
    $rose(state_ff == S_MANCAL) |-> (cnt_ff == 32'(MAN_CAL - 1)))
    else $error("manual calibration length wrong");
  a_idle_no_cal: assert property (@(posedge pclk) disable iff (!presetn)
    (strobe_ff[STB_IDLE] && state_ff != S_IDLE) |=> state_ff == S_IDLE)
    else $error("forced idle did not reach idle");
  a_rx_idle_fast: assert property (@(posedge pclk) disable iff (!presetn)
    (state_ff == S_RX_TO_IDLE && cnt_ff == 32'h00000001 &&
     !strobe_ff[STB_IDLE]) |=> ##1 state_ff == S_IDLE)
    else $error("receive to idle timing wrong");
  a_cs_term_idle: assert property (@(posedge pclk) disable iff (!presetn)
    (state_ff == S_RX && csterm && rx_ind.cs_valid && !cs_seen_ff &&
     !rx_ind.cs_carrier && !strobe_ff[STB_IDLE] && !strobe_ff[STB_TX] &&
     !strobe_ff[STB_FSTX]) |=>
     state_ff inside {S_RX_TO_IDLE, S_RX_CAL})
    else $error("carrier sense termination missed");
  a_idle_rx_len: assert property (@(posedge pclk) disable iff (!presetn)
    (state_ff == S_IDLE && strobe_ff[STB_RX] && !strobe_ff[STB_CAL] &&
     cal_mode != RSTC_CAL_TO_ACTIVE) |=>
     cnt_ff == 32'(CYC_IDLE_RX - 1))
    else $error("idle to receive count wrong");
  a_idle_tx_len: assert property (@(posedge pclk) disable iff (!presetn)
    (state_ff == S_IDLE && strobe_ff[STB_TX] && !strobe_ff[STB_CAL] &&
     !strobe_ff[STB_RX] && !strobe_ff[STB_IDLE] &&
     cal_mode != RSTC_CAL_TO_ACTIVE) |=>
     cnt_ff == 32'(CYC_IDLE_TX - 1))
    else $error("idle to transmit count wrong");
  a_turn_len: assert property (@(posedge pclk) disable iff (!presetn)
    (state_ff == S_RX && strobe_ff[STB_TX] && !strobe_ff[STB_IDLE]) |=>
     state_ff == S_TO_TX && cnt_ff == 32'(CYC_TURN - 1))
    else $error("turnaround count wrong");
  a_timer_load: assert property (@(posedge pclk) disable iff (!presetn)
    $rose(state_ff == S_RX) |-> rxtimer_ff == $past(rx_timeout_ff))
    else $error("termination timer not loaded");

endmodule : rstc_ctrl
`default_nettype wire

// *** src/rstc_pkg.sv ***
// package: register map, field layout and timing counts of the radio timing control
package rstc_pkg;

  // register byte offsets (apb, one aligned word each)
  localparam logic [7:0] OFS_CTRL      = 8'h00;
  localparam logic [7:0] OFS_STROBE    = 8'h04;
  localparam logic [7:0] OFS_BASE      = 8'h08;
  localparam logic [7:0] OFS_SPACING   = 8'h0C;
  localparam logic [7:0] OFS_SLOT      = 8'h10;
  localparam logic [7:0] OFS_IFTUNE    = 8'h14;
  localparam logic [7:0] OFS_POWER     = 8'h18;
  localparam logic [7:0] OFS_RXTIME    = 8'h1C;
  localparam logic [7:0] OFS_STATUS    = 8'h20;
  localparam logic [7:0] OFS_CARRIER   = 8'h24;
  localparam logic [7:0] OFS_SPCWORD   = 8'h28;
  localparam logic [7:0] OFS_IFWORD    = 8'h2C;

  // strobe register bit positions
  localparam int STB_RX    = 0;
  localparam int STB_TX    = 1;
  localparam int STB_FSTX  = 2;
  localparam int STB_IDLE  = 3;
  localparam int STB_CAL   = 4;

  // ctrl register field positions
  localparam int CTL_CAL_LSB   = 0;
  localparam int CTL_QUAL      = 2;
  localparam int CTL_CSTERM    = 3;
  localparam int CTL_RXOFF_LSB = 4;
  localparam int CTL_TXOFF_LSB = 6;

  // reset values
  localparam logic [23:0] RST_BASE    = 24'h000000;
  localparam logic [7:0]  RST_MANT    = 8'h00;
  localparam logic [1:0]  RST_EXP     = 2'h0;
  localparam logic [7:0]  RST_SLOT    = 8'h00;
  localparam logic [4:0]  RST_IFTUNE  = 5'h00;
  localparam logic [7:0]  RST_POWER   = 8'h00;
  localparam logic [15:0] RST_RXTIME  = 16'h0000;
  localparam logic [7:0]  RST_CTRL    = 8'h00;

  // transition counts in system clock cycles; CYC_AUTO_PERIOD counts automatic returns to idle
  localparam int CYC_IDLE_RX     = 1953;
  localparam int CYC_IDLE_ACT_CAL = 20768;
  localparam int CYC_IDLE_TX     = 1954;
  localparam int CYC_TURN        = 782;
  localparam int CYC_TX_IDLE_CAL = 18815;
  localparam int CYC_RX_IDLE     = 2;
  localparam int CYC_RX_IDLE_CAL = 18817;
  localparam int CYC_MAN_CAL     = 19098;
  localparam int CYC_AUTO_PERIOD = 4;

  typedef enum logic [1:0] {
    RSTC_CAL_NEVER, RSTC_CAL_TO_ACTIVE, RSTC_CAL_TO_IDLE, RSTC_CAL_FOURTH
  } rstc_cal_mode_t;

  typedef enum logic [1:0] {
    RSTC_OFF_IDLE, RSTC_OFF_FSTX, RSTC_OFF_TX, RSTC_OFF_RX
  } rstc_off_t;

  // receiver indications from the demodulator
  typedef struct packed {
    logic sync_found;
    logic pqt_above;
    logic cs_valid;
    logic cs_carrier;
    logic pkt_done;
  } rstc_rx_ind_t;

endpackage : rstc_pkg

// *** verif/rstc_tb.sv ***
// self-checking testbench for the radio state timing control block
`timescale 1ns/100ps
`default_nettype none
module testbench;
  import rstc_pkg::*;
  // shortened calibration counts keep the run brief
  localparam int ACT_CAL = 20;
  localparam int TXI_CAL = 22;
  localparam int RXI_CAL = 24;
  localparam int MAN_CYC = 26;
  // one cycle for a strobe to act, one for the registered outputs
  localparam int LAT     = 2;
  localparam int BOUND   = 30000;

  logic         pclk;
  logic         presetn;
  logic         psel;
  logic         penable;
  logic         pwrite;
  logic [7:0]   paddr;
  logic [31:0]  pwdata;
  logic         pready;
  logic [31:0]  prdata;
  logic         pslverr;
  logic         quarter_sym_tick = 1'b0;
  rstc_rx_ind_t rx_ind;
  logic         rx_active_ff;
  logic         tx_active_ff;
  logic         synth_on_ff;
  logic         cal_busy_ff;
  logic [7:0]   output_power_setting_ff;
  logic         tick_en;
  logic [3:0]   tick_cnt_ff = 4'h0;
  int           fail_count;
  int           n_tests;
  int           n;
  int           cals;
  logic         saw;
  logic [31:0]  rd;
  logic [7:0]   offs [8] = '{OFS_CTRL, OFS_STROBE, OFS_BASE, OFS_SPACING,
                             OFS_SLOT, OFS_POWER, OFS_RXTIME, 8'h30};
  logic [7:0]   pw [3] = '{8'hFF, 8'h00, 8'h5A};

  rstc_ctrl #(.IDLE_ACT_CAL(ACT_CAL), .TX_IDLE_CAL(TXI_CAL),
              .RX_IDLE_CAL(RXI_CAL), .MAN_CAL(MAN_CYC)) uut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
    .prdata(prdata), .pslverr(pslverr),
    .quarter_sym_tick(quarter_sym_tick), .rx_ind(rx_ind),
    .rx_active_ff(rx_active_ff), .tx_active_ff(tx_active_ff),
    .synth_on_ff(synth_on_ff), .cal_busy_ff(cal_busy_ff),
    .output_power_setting_ff(output_power_setting_ff));

  always #12.5 pclk = ~pclk;

  // quarter-symbol pulse every 16 cycles; can be held off to stall turnaround
  always @(posedge pclk) begin
    tick_cnt_ff      <= tick_cnt_ff + 4'h1;
    quarter_sym_tick <= tick_en && (tick_cnt_ff == 4'hF);
  end

  ////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      fail_count++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic print_verdict();
    $display("comparisons %0d mismatches %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : print_verdict

  task automatic stop_hang();
    chk(32'h0, 32'h1);
    print_verdict();
  endtask : stop_hang

  task automatic apb(input logic wr, input logic [7:0] a,
                     input logic [31:0] d, output logic [31:0] q);
    int k;
    k = 0;
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      k++;
    end while (pready !== 1'b1 && k < 20);
    q = prdata;
    psel    <= 1'b0;
    penable <= 1'b0;
    if (k >= 20) stop_hang();
  endtask : apb

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    apb(1'b1, a, d, q);
  endtask : wr

  task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] q;
    apb(1'b0, a, 32'h0, q);
    chk(q, exp);
  endtask : rdchk

  task automatic stb(input int b);
    wr(OFS_STROBE, 32'h1 << b);
  endtask : stb

  function automatic logic pick(input int s);
    case (s)
      0: return rx_active_ff;
      1: return tx_active_ff;
      default: return cal_busy_ff;
    endcase
  endfunction : pick

  // counts edges, from the last one, until the chosen output shows lvl
  task automatic wait_for(input int s, input logic lvl, output int c);
    c = 0;
    do begin
      @(posedge pclk);
      #1;
      c++;
    end while (pick(s) !== lvl && c < BOUND);
    if (c >= BOUND) stop_hang();
  endtask : wait_for

  task automatic watch_cal(output logic s);
    s = 1'b0;
    repeat (60) begin
      @(posedge pclk);
      #1;
      if (cal_busy_ff === 1'b1) s = 1'b1;
    end
  endtask : watch_cal

  task automatic pkt_pulse();
    @(posedge pclk);
    rx_ind.pkt_done <= 1'b1;
    @(posedge pclk);
    rx_ind.pkt_done <= 1'b0;
  endtask : pkt_pulse

  task automatic set_ind(input logic sy, input logic pq, input logic cv,
                         input logic cc);
    @(posedge pclk);
    rx_ind <= '{sync_found: sy, pqt_above: pq, cs_valid: cv,
                cs_carrier: cc, pkt_done: 1'b0};
  endtask : set_ind

  // enter receive, wait for its automatic end, then watch for calibration
  task automatic rx_cycle(output logic s, output int f);
    int c;
    stb(STB_RX);
    wait_for(0, 1'b1, c);
    wait_for(0, 1'b0, f);
    watch_cal(s);
  endtask : rx_cycle

  task automatic rx_stay(input logic [7:0] ctl, input logic sy,
                         input logic pq, input logic exp);
    int c;
    wr(OFS_CTRL, {24'h0, ctl});
    set_ind(sy, pq, 1'b0, 1'b0);
    stb(STB_RX);
    wait_for(0, 1'b1, c);
    repeat (120) @(posedge pclk);
    #1;
    chk(rx_active_ff, exp);
    stb(STB_IDLE);
  endtask : rx_stay

  task automatic carrier_base_word_case(input logic [23:0] b, input logic [7:0] m,
                           input logic [1:0] e, input logic [7:0] s,
                           input logic [4:0] t);
    logic [31:0] spc;
    spc = (32'd256 + m) << e;
    wr(OFS_BASE, {8'h00, b});
    wr(OFS_SPACING, {22'h0, e, m});
    wr(OFS_SLOT, {24'h0, s});
    wr(OFS_IFTUNE, {27'h0, t});
    repeat (2) @(posedge pclk);
    rdchk(OFS_BASE, {8'h00, b});
    rdchk(OFS_SPCWORD, spc);
    rdchk(OFS_CARRIER, {6'h0, b, 2'b00} + s * spc);
    rdchk(OFS_IFWORD, {27'h0, t});
  endtask : carrier_base_word_case

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    pclk       = 1'b0;
    presetn    = 1'b0;
    psel       = 1'b0;
    penable    = 1'b0;
    pwrite     = 1'b0;
    paddr      = 8'h00;
    pwdata     = 32'h0;
    rx_ind     = '0;
    tick_en    = 1'b1;
    fail_count = 0;
    n_tests    = 0;
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    for (int i = 0; i < 8; i++) rdchk(offs[i], 32'h0);
    chk(output_power_setting_ff, 8'h00);
    $display("test reset values done");
    for (int i = 0; i < 3; i++) begin
      wr(OFS_POWER, {24'h0, pw[i]});
      rdchk(OFS_POWER, {24'h0, pw[i]});
      chk(output_power_setting_ff, pw[i]);
    end
    $display("test power setting done");
    carrier_base_word_case(24'h123456, 8'h3B, 2'h2, 8'h05, 5'h0C);
    carrier_base_word_case(24'hFFFFFF, 8'hFF, 2'h3, 8'hFF, 5'h1F);
    $display("test frequency words done");
    wr(OFS_CTRL, 32'h0);
    stb(STB_CAL);
    repeat (MAN_CYC + 4) @(posedge pclk);
    stb(STB_RX);
    wait_for(0, 1'b1, n);
    chk(n, CYC_IDLE_RX + LAT);
    stb(STB_TX);
    wait_for(1, 1'b1, n);
    chk(n, CYC_TURN + LAT);
    tick_en = 1'b0;
    stb(STB_RX);
    repeat (CYC_TURN + 40) @(posedge pclk);
    #1;
    chk(rx_active_ff, 1'b0);
    tick_en = 1'b1;
    wait_for(0, 1'b1, n);
    chk(n <= 20, 1'b1);
    wr(OFS_CTRL, 32'h2);
    stb(STB_IDLE);
    watch_cal(saw);
    chk(saw, 1'b0);
    stb(STB_TX);
    wait_for(1, 1'b1, n);
    chk(n, CYC_IDLE_TX + LAT);
    stb(STB_IDLE);
    wr(OFS_CTRL, 32'h1);
    stb(STB_RX);
    wait_for(0, 1'b1, n);
    chk(n, ACT_CAL + LAT);
    stb(STB_IDLE);
    stb(STB_FSTX);
    repeat (ACT_CAL + LAT) @(posedge pclk);
    apb(1'b0, OFS_STATUS, 32'h0, rd);
    chk(rd[3:0], 4'h6);
    chk(synth_on_ff, 1'b1);
    stb(STB_IDLE);
    $display("test transition timing done");
    wr(OFS_CTRL, 32'h0);
    stb(STB_CAL);
    wait_for(2, 1'b1, n);
    wait_for(2, 1'b0, n);
    chk(n, MAN_CYC);
    $display("test manual calibration done");
    wr(OFS_RXTIME, 32'd50);
    wr(OFS_CTRL, 32'h30);
    rx_cycle(saw, n);
    chk(n >= 50 && n <= 53, 1'b1);
    chk(saw, 1'b0);
    apb(1'b0, OFS_STATUS, 32'h0, rd);
    chk(rd[3:0], 4'h0);
    rx_stay(8'h30, 1'b1, 1'b0, 1'b1);
    rx_stay(8'h30, 1'b0, 1'b1, 1'b0);
    rx_stay(8'h34, 1'b0, 1'b1, 1'b1);
    rx_stay(8'h34, 1'b0, 1'b0, 1'b0);
    $display("test receive timeout done");
    wr(OFS_RXTIME, 32'h0);
    wr(OFS_CTRL, 32'h38);
    set_ind(1'b0, 1'b0, 1'b1, 1'b0);
    rx_cycle(saw, n);
    chk(n <= 10, 1'b1);
    apb(1'b0, OFS_STATUS, 32'h0, rd);
    chk(rd[3:0], 4'h0);
    $display("test carrier termination done");
    set_ind(1'b0, 1'b0, 1'b0, 1'b0);
    wr(OFS_RXTIME, 32'd50);
    wr(OFS_CTRL, 32'h2);
    rx_cycle(saw, n);
    chk(saw, 1'b1);
    wr(OFS_CTRL, 32'h3);
    cals = 0;
    repeat (4) begin
      rx_cycle(saw, n);
      cals += int'(saw);
    end
    chk(cals, 1);
    $display("test auto calibration done");
    for (int i = 0; i < 2; i++) begin
      wr(OFS_CTRL, (i == 0) ? 32'h2 : 32'h0);
      stb(STB_TX);
      wait_for(1, 1'b1, n);
      pkt_pulse();
      wait_for(1, 1'b0, n);
      chk(n, 1);
      watch_cal(saw);
      chk(saw, i == 0);
      apb(1'b0, OFS_STATUS, 32'h0, rd);
      chk(rd[3:0], 4'h0);
    end
    $display("test transmit end done");
    print_verdict();
  end
endmodule : testbench
`default_nettype wire
